//--- common/scs_regs.svh
/*
 * Register offsets, field positions, reset values and nominal rates of the
 * system clock selector.
 * Assumes inclusion by bare name from the package; the design files see it through that.
 */
`ifndef SCS_REGS_SVH
`define SCS_REGS_SVH

// Register indices on the plain register port
`define SCS_OFS_CLOCK_DIVISOR   4'h0
`define SCS_OFS_PLL_FEEDBACK    4'h1
`define SCS_OFS_FRC_TUNE        4'h2
`define SCS_OFS_STATUS          4'h3

// Clock divisor register fields
`define SCS_FRC_DIV_MSB         10
`define SCS_FRC_DIV_LSB         8
`define SCS_POST_MSB            7
`define SCS_POST_LSB            6
`define SCS_PRE_MSB             4
`define SCS_PRE_LSB             0

// Feedback and tuning fields
`define SCS_FBD_MSB             8
`define SCS_FBD_LSB             0
`define SCS_TUNE_MSB            5
`define SCS_TUNE_LSB            0

// Status register fields
`define SCS_STAT_SEL_LSB        0
`define SCS_STAT_MODE_LSB       4
`define SCS_STAT_PLL_BIT        8

// Reset values
`define SCS_RST_FRC_DIV         3'h0
`define SCS_RST_POST            2'h0
`define SCS_RST_PRE             5'h00
`define SCS_RST_FBD             9'h030
`define SCS_RST_TUNE            6'h00

// Nominal rates in kHz and the system clock period in ps
`define SCS_FRC_NOMINAL_KHZ     7370
`define SCS_SLOW_INTERNAL_RC_NOMINAL_KHZ    32.768
`define SCS_CLK_PERIOD_PS       5000

`endif

//--- common/scs_pkg.sv
/*
 * Types of the system clock selector.
 * Assumes scs_regs.svh is on the include path.
 */
package scs_pkg;
`include "scs_regs.svh"

    typedef enum logic [2:0] {
        SCS_SEL_FRC       = 3'h0,
        SCS_SEL_FRC_PLL   = 3'h1,
        SCS_SEL_PRIM      = 3'h2,
        SCS_SEL_PRIM_PLL  = 3'h3,
        SCS_SEL_SECONDARY_CRYSTAL_OSC      = 3'h4,
        SCS_SEL_SLOW_INTERNAL_RC      = 3'h5,
        SCS_SEL_FRC_DIV16 = 3'h6,
        SCS_SEL_FRC_DIVN  = 3'h7
    } scs_osc_sel_t;

    typedef enum logic [1:0] {
        SCS_PM_EXT_CLOCK  = 2'h0,
        SCS_PM_CRYSTAL    = 2'h1,
        SCS_PM_HS_CRYSTAL = 2'h2,
        SCS_PM_OFF        = 2'h3
    } scs_prim_mode_t;

    typedef struct packed {
        logic [3:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } scs_bus_req_t;

    typedef struct packed {
        logic           cfg_done;
        scs_osc_sel_t   cfg_sel;
        scs_prim_mode_t cfg_mode;
        logic           cfg_pin_fn;
        logic [2:0]     frc_div;
        logic [1:0]     post;
        logic [4:0]     pre;
        logic [8:0]     fbd;
        logic [5:0]     tune;
        logic [11:0]    acc;
        logic [7:0]     div_cnt;
        logic           fcy_phase;
        logic           fosc_tick;
        logic           fcy_tick;
        logic           wdt_tick;
        logic [15:0]    rdata;
    } scs_state_t;
endpackage

//--- src/scs_clock_select.sv
/*
 * System clock selector: picks the oscillator from the nonvolatile fields at
 * power-on, runs an optional rate-model PLL and dividers, and halves the
 * result into instruction and peripheral clock enables.
 * Assumes oscillator edges arrive as one-cycle tick inputs, synchronous to
 * I_CLOCK and no more often than every other cycle after multiplication.
 */
module scs_clock_select
    import scs_pkg::*;
#(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 4
) (
    input  wire logic        I_CLOCK,
    input  wire logic        I_RSTN,
    input  wire logic [3:0]  I_ADDR,
    input  wire logic [15:0] I_WDATA,
    input  wire logic        I_WR,
    input  wire logic        I_RD,
    output logic      [15:0] O_RDATA,
    input  wire logic [2:0]  I_CFG_OSC_SEL,
    input  wire logic [1:0]  I_CFG_PRIM_MODE,
    input  wire logic        I_CFG_PIN_FN,
    input  wire logic        I_FRC_TICK,
    input  wire logic        I_PRIM_TICK,
    input  wire logic        I_SECONDARY_CRYSTAL_OSC_TICK,
    input  wire logic        I_SLOW_INTERNAL_RC_TICK,
    output logic      [5:0]  O_FRC_TUNE,
    output logic      [1:0]  O_PRIM_MODE,
    output logic             O_OSC2_IS_IO,
    output logic             O_PLL_ACTIVE,
    output logic             O_FOSC_TICK,
    output logic             O_FCY_TICK,
    output logic             O_FP_TICK,
    output logic             O_WDT_REF_TICK
);

    initial begin
        if (DATA_W != 16 || ADDR_W != 4) begin
            $error("scs_clock_select serves only 16-bit data, 4-bit address");
        end
    end

    scs_state_t   q;
    scs_state_t   next_q;
    scs_bus_req_t bus;

    assign bus = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};

    // N2 from the postscaler code; code 2 is taken as 4
    function automatic logic [3:0] post_div(input logic [1:0] code);
        unique case (code)
            2'h0:    post_div = 4'h2;
            2'h3:    post_div = 4'h8;
            default: post_div = 4'h4;
        endcase
    endfunction

    // Division threshold N1 * N2
    function automatic logic [11:0] pll_thr(input logic [4:0] pre,
                                            input logic [1:0] post);
        logic [5:0] n1;
        n1 = {1'b0, pre} + 6'h02;
        pll_thr = {6'h00, n1} * {8'h00, post_div(post)};
    endfunction

    // Divide count minus one after the source mux
    function automatic logic [7:0] div_m1(input scs_osc_sel_t sel,
                                          input logic [2:0] f);
        unique case (sel)
            SCS_SEL_FRC_DIV16: div_m1 = 8'h0F;
            SCS_SEL_FRC_DIVN:  div_m1 = 8'((9'h002 << f) - 9'h001);
            default:           div_m1 = 8'h00;
        endcase
    endfunction

    logic        pll_on;
    logic        src_tick;
    logic [11:0] thr;
    logic [11:0] mul;
    logic        emit;
    logic        pre_div_tick;

    always_comb begin
        next_q = q;
        next_q.fosc_tick = 1'b0;
        next_q.fcy_tick = 1'b0;
        next_q.wdt_tick = I_SLOW_INTERNAL_RC_TICK;
        next_q.rdata = 16'h0000;
        pll_on = 1'b0;
        src_tick = 1'b0;
        emit = 1'b0;
        pre_div_tick = 1'b0;
        thr = pll_thr(q.pre, q.post);
        mul = {3'h0, q.fbd} + 12'h002;

        // Catch the nonvolatile fields once after reset release
        if (!q.cfg_done) begin
            next_q.cfg_sel = scs_osc_sel_t'(I_CFG_OSC_SEL);
            next_q.cfg_mode = scs_prim_mode_t'(I_CFG_PRIM_MODE);
            next_q.cfg_pin_fn = I_CFG_PIN_FN;
            next_q.cfg_done = 1'b1;
        end

        if (bus.wr) begin
            unique case (bus.addr)
                `SCS_OFS_CLOCK_DIVISOR: begin
                    next_q.frc_div =
                        bus.wdata[`SCS_FRC_DIV_MSB:`SCS_FRC_DIV_LSB];
                    next_q.post = bus.wdata[`SCS_POST_MSB:`SCS_POST_LSB];
                    next_q.pre = bus.wdata[`SCS_PRE_MSB:`SCS_PRE_LSB];
                end
                `SCS_OFS_PLL_FEEDBACK: begin
                    next_q.fbd = bus.wdata[`SCS_FBD_MSB:`SCS_FBD_LSB];
                end
                `SCS_OFS_FRC_TUNE: begin
                    next_q.tune = bus.wdata[`SCS_TUNE_MSB:`SCS_TUNE_LSB];
                end
                default: begin
                end
            endcase
        end

        if (bus.rd) begin
            unique case (bus.addr)
                `SCS_OFS_CLOCK_DIVISOR: begin
                    next_q.rdata[`SCS_FRC_DIV_MSB:`SCS_FRC_DIV_LSB] = q.frc_div;
                    next_q.rdata[`SCS_POST_MSB:`SCS_POST_LSB] = q.post;
                    next_q.rdata[`SCS_PRE_MSB:`SCS_PRE_LSB] = q.pre;
                end
                `SCS_OFS_PLL_FEEDBACK: begin
                    next_q.rdata[`SCS_FBD_MSB:`SCS_FBD_LSB] = q.fbd;
                end
                `SCS_OFS_FRC_TUNE: begin
                    next_q.rdata[`SCS_TUNE_MSB:`SCS_TUNE_LSB] = q.tune;
                end
                `SCS_OFS_STATUS: begin
                    next_q.rdata[`SCS_STAT_SEL_LSB +: 3] = q.cfg_sel;
                    next_q.rdata[`SCS_STAT_MODE_LSB +: 2] = q.cfg_mode;
                    next_q.rdata[`SCS_STAT_PLL_BIT] = O_PLL_ACTIVE;
                end
                default: begin
                end
            endcase
        end

        // Source mux; only fast RC and primary reach the PLL
        if (q.cfg_done) begin
            unique case (q.cfg_sel)
                SCS_SEL_FRC, SCS_SEL_FRC_DIV16, SCS_SEL_FRC_DIVN:
                    src_tick = I_FRC_TICK;
                SCS_SEL_FRC_PLL: begin
                    src_tick = I_FRC_TICK;
                    pll_on = 1'b1;
                end
                SCS_SEL_PRIM:
                    src_tick = I_PRIM_TICK;
                SCS_SEL_PRIM_PLL: begin
                    src_tick = I_PRIM_TICK;
                    pll_on = 1'b1;
                end
                SCS_SEL_SECONDARY_CRYSTAL_OSC:
                    src_tick = I_SECONDARY_CRYSTAL_OSC_TICK;
                SCS_SEL_SLOW_INTERNAL_RC:
                    src_tick = I_SLOW_INTERNAL_RC_TICK;
            endcase
        end

        // Rate model of the PLL: out rate = in * M / (N1 * N2)
        if (pll_on) begin
            emit = q.acc >= thr;
            next_q.acc = q.acc + (src_tick ? mul : 12'h000)
                         - (emit ? thr : 12'h000);
            pre_div_tick = emit;
        end else begin
            next_q.acc = 12'h000;
            pre_div_tick = src_tick;
        end

        // Fast RC postscaler and divide-by-16
        if (pre_div_tick) begin
            if (q.div_cnt >= div_m1(q.cfg_sel, q.frc_div)) begin
                next_q.div_cnt = 8'h00;
                next_q.fosc_tick = 1'b1;
            end else begin
                next_q.div_cnt = q.div_cnt + 8'h01;
            end
        end

        // Instruction clock is every second system tick
        if (q.fosc_tick) begin
            next_q.fcy_phase = ~q.fcy_phase;
            next_q.fcy_tick = q.fcy_phase;
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            q <= '{cfg_done: 1'b0, cfg_sel: SCS_SEL_FRC_DIVN,
                   cfg_mode: SCS_PM_OFF, cfg_pin_fn: 1'b0,
                   frc_div: `SCS_RST_FRC_DIV, post: `SCS_RST_POST,
                   pre: `SCS_RST_PRE, fbd: `SCS_RST_FBD,
                   tune: `SCS_RST_TUNE, acc: 12'h000, div_cnt: 8'h00,
                   fcy_phase: 1'b0, fosc_tick: 1'b0, fcy_tick: 1'b0,
                   wdt_tick: 1'b0, rdata: 16'h0000};
        end else begin
            q <= next_q;
        end
    end

    logic prim_sel;
    assign prim_sel = q.cfg_sel == SCS_SEL_PRIM
                   || q.cfg_sel == SCS_SEL_PRIM_PLL;

    assign O_RDATA = q.rdata;
    assign O_FRC_TUNE = q.tune;
    assign O_PRIM_MODE = prim_sel ? q.cfg_mode : SCS_PM_OFF;
    // Pin free for I/O when the pin field asks for it, unless primary is selected in any mode other than external clock
    assign O_OSC2_IS_IO = q.cfg_pin_fn && !(prim_sel
                          && q.cfg_mode != SCS_PM_EXT_CLOCK);
    assign O_PLL_ACTIVE = q.cfg_done && (q.cfg_sel == SCS_SEL_FRC_PLL
                          || q.cfg_sel == SCS_SEL_PRIM_PLL);
    assign O_FOSC_TICK = q.fosc_tick;
    assign O_FCY_TICK = q.fcy_tick;
    assign O_FP_TICK = q.fcy_tick;
    assign O_WDT_REF_TICK = q.wdt_tick;

    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RSTN);

    a_cfg_capture: assert property ($rose(q.cfg_done) |->
        q.cfg_sel == $past(I_CFG_OSC_SEL)
        && q.cfg_mode == $past(I_CFG_PRIM_MODE))
        else $error("config fields not captured at reset release");
    a_erased_default: assert property (!q.cfg_done |->
        q.cfg_sel == SCS_SEL_FRC_DIVN)
        else $error("pre-load selection is not fast RC divide-by-N");
    a_fcy_from_fosc: assert property (O_FCY_TICK |->
        $past(O_FOSC_TICK) && !q.fcy_phase)
        else $error("instruction tick without preceding system tick");
    a_fcy_half: assert property (O_FOSC_TICK && q.fcy_phase |=>
        O_FCY_TICK && O_FP_TICK)
        else $error("second system tick did not give instruction tick");
    a_pll_bypass: assert property (!O_PLL_ACTIVE |=> q.acc == 12'h000)
        else $error("PLL accumulator busy while bypassed");
    a_pll_emit: assert property (O_PLL_ACTIVE && !$past(q.acc >= thr)
        && $stable(q.cfg_sel) |-> q.acc >= $past(q.acc))
        else $error("PLL accumulator lost count without an output tick");
    a_wdt_ref: assert property (I_SLOW_INTERNAL_RC_TICK |=> O_WDT_REF_TICK)
        else $error("slow RC edge not passed to watchdog reference");
    a_slow_direct: assert property (q.cfg_done
        && q.cfg_sel == SCS_SEL_SLOW_INTERNAL_RC && I_SLOW_INTERNAL_RC_TICK |=> O_FOSC_TICK)
        else $error("slow RC edge did not reach system tick");
    a_div_write: assert property (bus.wr
        && bus.addr == `SCS_OFS_CLOCK_DIVISOR |=>
        q.frc_div == $past(I_WDATA[`SCS_FRC_DIV_MSB:`SCS_FRC_DIV_LSB]))
        else $error("divider field not written");
    a_tune_out: assert property (bus.wr && bus.addr == `SCS_OFS_FRC_TUNE
        |=> O_FRC_TUNE == $past(I_WDATA[`SCS_TUNE_MSB:`SCS_TUNE_LSB]))
        else $error("tuning value not applied");
    a_prim_mode: assert property (q.cfg_done && !prim_sel |->
        O_PRIM_MODE == SCS_PM_OFF)
        else $error("primary oscillator enabled while unselected");

    c_pll_tick: cover property (O_PLL_ACTIVE && O_FOSC_TICK);
    c_divn_fcy: cover property (q.cfg_sel == SCS_SEL_FRC_DIVN && O_FCY_TICK);
    c_div16: cover property (q.cfg_sel == SCS_SEL_FRC_DIV16 && O_FOSC_TICK);
    c_status_rd: cover property (I_RD && I_ADDR == `SCS_OFS_STATUS);

endmodule

//--- bench/scs_osc_src.sv
/*
 * Free-running oscillator sources for the system clock selector: each
 * source gives a one-cycle tick every so many system clock cycles.
 * Assumes the periods are far above two cycles so that the multiplied
 * output stays within one tick every other cycle.
 */
module scs_osc_src #(
    parameter int FRC_P  = 4,
    parameter int PRIM_P = 6,
    parameter int SECONDARY_CRYSTAL_OSC_P = 10,
    parameter int SLOW_INTERNAL_RC_P = 14
) (
    input  wire logic i_clock,
    output logic      o_frc_tick,
    output logic      o_prim_tick,
    output logic      o_secondary_crystal_osc_tick,
    output logic      o_slow_internal_rc_tick
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int PER [4] = '{FRC_P, PRIM_P, SECONDARY_CRYSTAL_OSC_P, SLOW_INTERNAL_RC_P};

    // Staggered phases, sources unrelated to each other
    int         cnt [4] = '{0, 1, 2, 3};
    logic [3:0] tick    = 4'h0;

    always @(posedge i_clock) begin
        for (int k = 0; k < 4; k++) begin
            cnt[k]  <= (cnt[k] == PER[k] - 1) ? 0 : cnt[k] + 1;
            tick[k] <= (cnt[k] == PER[k] - 1);
        end
    end

    assign o_frc_tick  = tick[0];
    assign o_prim_tick = tick[1];
    assign o_secondary_crystal_osc_tick = tick[2];
    assign o_slow_internal_rc_tick = tick[3];
endmodule

//--- bench/tb_top.sv
/*
 * Testbench of the system clock selector: register access, decoding of
 * the power-on select fields and tick rates through dividers and PLL.
 * Assumes the source model runs FAST_INTERNAL_RC/4, primary/6, secondary/10, slow RC/14.
 */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int W = 1680;
    localparam int N = 11;
    localparam int T_CODE [N] = '{0, 1, 1, 2, 3, 3, 4, 5, 6, 7, 7};
    localparam int T_MODE [N] = '{0, 0, 3, 1, 2, 0, 1, 2, 0, 0, 1};
    localparam logic [15:0] T_R0 [N] = '{16'h00C0, 16'h00C0, 16'h0000,
        16'h0000, 16'h0042, 16'h0000, 16'h00C0, 16'h00C0, 16'h0200,
        16'h0000, 16'h0200};
    localparam logic [15:0] T_R1 [N] = '{16'h0006, 16'h0006, 16'h0000,
        16'h0030, 16'h0006, 16'h0000, 16'h0006, 16'h0006, 16'h0030,
        16'h0030, 16'h0030};
    localparam int T_EXP [N] = '{420, 210, 210, 280, 140, 140, 168, 120,
        26, 210, 52};
    localparam logic [15:0] MASK [5] = '{16'h07DF, 16'h01FF, 16'h003F,
        16'h0007, 16'h0000};

    logic        I_CLOCK         = 1'b0;
    logic        I_RSTN          = 1'b0;
    logic [3:0]  I_ADDR          = 4'h0;
    logic [15:0] I_WDATA         = 16'h0000;
    logic        I_WR            = 1'b0;
    logic        I_RD            = 1'b0;
    logic [2:0]  I_CFG_OSC_SEL   = 3'h7;
    logic [1:0]  I_CFG_PRIM_MODE = 2'h0;
    logic        I_CFG_PIN_FN    = 1'b0;
    logic        frc_tick;
    logic        prim_tick;
    logic        secondary_crystal_osc_tick;
    logic        slow_internal_rc_tick;
    logic [15:0] O_RDATA;
    logic [5:0]  O_FRC_TUNE;
    logic [1:0]  O_PRIM_MODE;
    logic        O_OSC2_IS_IO;
    logic        O_PLL_ACTIVE;
    logic        O_FOSC_TICK;
    logic        O_FCY_TICK;
    logic        O_FP_TICK;
    logic        O_WDT_REF_TICK;
    int          fails   = 0;
    int          n_tests = 0;

    always #2.5 I_CLOCK = ~I_CLOCK;

    scs_osc_src i_scs_osc_src (
        .i_clock     (I_CLOCK),
        .o_frc_tick  (frc_tick),
        .o_prim_tick (prim_tick),
        .o_secondary_crystal_osc_tick (secondary_crystal_osc_tick),
        .o_slow_internal_rc_tick (slow_internal_rc_tick)
    );

    scs_clock_select i_scs_clock_select (
        .I_CLOCK         (I_CLOCK),
        .I_RSTN          (I_RSTN),
        .I_ADDR          (I_ADDR),
        .I_WDATA         (I_WDATA),
        .I_WR            (I_WR),
        .I_RD            (I_RD),
        .O_RDATA         (O_RDATA),
        .I_CFG_OSC_SEL   (I_CFG_OSC_SEL),
        .I_CFG_PRIM_MODE (I_CFG_PRIM_MODE),
        .I_CFG_PIN_FN    (I_CFG_PIN_FN),
        .I_FRC_TICK      (frc_tick),
        .I_PRIM_TICK     (prim_tick),
        .I_SECONDARY_CRYSTAL_OSC_TICK     (secondary_crystal_osc_tick),
        .I_SLOW_INTERNAL_RC_TICK     (slow_internal_rc_tick),
        .O_FRC_TUNE      (O_FRC_TUNE),
        .O_PRIM_MODE     (O_PRIM_MODE),
        .O_OSC2_IS_IO    (O_OSC2_IS_IO),
        .O_PLL_ACTIVE    (O_PLL_ACTIVE),
        .O_FOSC_TICK     (O_FOSC_TICK),
        .O_FCY_TICK      (O_FCY_TICK),
        .O_FP_TICK       (O_FP_TICK),
        .O_WDT_REF_TICK  (O_WDT_REF_TICK)
    );

    task automatic chk(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic bit near(input int a, input int b);
        return (a - b <= 1) && (b - a <= 1);
    endfunction

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge I_CLOCK);
        I_WR    <= 1'b1;
        I_ADDR  <= a;
        I_WDATA <= d;
        @(posedge I_CLOCK);
        I_WR    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge I_CLOCK);
        I_RD   <= 1'b1;
        I_ADDR <= a;
        @(posedge I_CLOCK);
        I_RD   <= 1'b0;
        #1;
        d = O_RDATA;
    endtask

    // Config is disturbed after capture to show it is held
    task automatic do_reset(input logic [2:0] sel, input logic [1:0] pm,
                            input logic pf, input int n);
        I_CFG_OSC_SEL   <= sel;
        I_CFG_PRIM_MODE <= pm;
        I_CFG_PIN_FN    <= pf;
        I_RSTN          <= 1'b0;
        repeat (n) @(posedge I_CLOCK);
        I_RSTN <= 1'b1;
        repeat (2) @(posedge I_CLOCK);
        I_CFG_OSC_SEL   <= ~sel;
        I_CFG_PRIM_MODE <= ~pm;
        I_CFG_PIN_FN    <= ~pf;
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        #300000;
        fails++;
        print_verdict();
    end

    initial begin
        logic [15:0] d;
        logic [2:0]  c;
        logic [1:0]  pm;
        logic        pll;
        logic        pf;
        int          nf;
        int          nc;
        int          np;
        int          nw;
        do_reset(3'h7, 2'h0, 1'b0, 10);
        rd(4'h0, d);
        chk("divisor reset", d, 16'h0000);
        rd(4'h1, d);
        chk("feedback reset", d, 16'h0030);
        rd(4'h2, d);
        chk("tune reset", d, 16'h0000);
        for (int a = 0; a < 5; a++) begin
            wr(a[3:0], 16'hFFFF);
            rd(a[3:0], d);
            chk("register mask", d, MASK[a]);
        end
        chk("tune out", {10'h000, O_FRC_TUNE}, 16'h003F);
        @(posedge I_CLOCK);
        #1;
        chk("rdata idle", O_RDATA, 16'h0000);
        wr(4'h2, 16'h002A);
        rd(4'h2, d);
        chk("tune out", {10'h000, O_FRC_TUNE}, 16'h002A);
        $display("test registers done");
        for (int i = 0; i < N; i++) begin
            c   = T_CODE[i][2:0];
            pf  = i[0];
            pm  = (c == 3'h2 || c == 3'h3) ? T_MODE[i][1:0] : 2'h3;
            pll = (c == 3'h1 || c == 3'h3);
            do_reset(c, T_MODE[i][1:0], pf, 3);
            wr(4'h1, T_R1[i]);
            wr(4'h0, T_R0[i]);
            rd(4'h3, d);
            chk("status", d,
                {7'h00, pll, 2'h0, T_MODE[i][1:0], 1'b0, c});
            chk("prim mode", {14'h0000, O_PRIM_MODE}, {14'h0000, pm});
            chk("pll active", {15'h0000, O_PLL_ACTIVE}, {15'h0000, pll});
            chk("pin fn", {15'h0000, O_OSC2_IS_IO},
                {15'h0000, pf && pm != 2'h1 && pm != 2'h2});
            repeat (200) @(posedge I_CLOCK);
            nf = 0;
            nc = 0;
            np = 0;
            nw = 0;
            repeat (W) begin
                @(posedge I_CLOCK);
                #1;
                nf += (O_FOSC_TICK === 1'b1);
                nc += (O_FCY_TICK === 1'b1);
                np += (O_FP_TICK === 1'b1);
                nw += (O_WDT_REF_TICK === 1'b1);
            end
            chk("fosc rate", near(nf, T_EXP[i]), 1'b1);
            chk("fcy rate", near(nc, T_EXP[i] / 2), 1'b1);
            chk("fp rate", np == nc, 1'b1);
            chk("wdt rate", near(nw, W / 14), 1'b1);
            $display("test select entry %0d done", i);
        end
        print_verdict();
    end
endmodule
